// ---- core/linear_sensor_serial_control.sv ----
// Command receiver, register bank, pixel sequencing and serial transmitter
`timescale 1ns/1ps
`default_nettype none
module linear_sensor_serial_control
   import lsc_pkg::*;
(
   // Serial clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Serial link
   input wire logic command_serial_in,
   output logic data_serial_out,
   // Analog front end
   input wire logic [7:0] pixel_level [PIXEL_COUNT],
   output logic integrators_reset,
   output logic integrating,
   output logic analog_sleep
);
   // Receiver
   rx_state_t rx_state_reg;
   logic [3:0] rx_bit_reg;
   logic [7:0] rx_shift_reg;
   logic [3:0] zero_run_reg;
   logic [1:0] reset_run_reg;
   logic expect_data_reg;
   logic [4:0] store_addr_reg;
   logic [7:0] rx_word;
   logic byte_done;
   logic line_break;
   assign rx_word = {command_serial_in, rx_shift_reg[7:1]};
   assign byte_done = (rx_state_reg == RX_DATA) && (rx_bit_reg == WORD_BITS - 4'h1);
   // Held for the whole break, so no frame can begin inside a long run of zeros
   assign line_break = (zero_run_reg >= BREAK_ZEROS - 4'h1) && !command_serial_in;
   // Receiver has no stop-bit state, so a start may follow the last data bit
   always_ff @(posedge mclk)
   begin
      if (!nrst || line_break)
      begin
         rx_state_reg <= RX_IDLE;
         rx_bit_reg <= 4'h0;
         rx_shift_reg <= 8'h00;
      end
      else if (rx_state_reg == RX_IDLE)
      begin
         if (!command_serial_in)
         begin
            rx_state_reg <= RX_DATA;
            rx_bit_reg <= 4'h0;
         end
      end
      else
      begin
         rx_shift_reg <= rx_word;
         rx_bit_reg <= rx_bit_reg + 4'h1;
         if (byte_done)
            rx_state_reg <= RX_IDLE;
      end
   end
   always_ff @(posedge mclk)
   begin
      if (!nrst || command_serial_in)
         zero_run_reg <= 4'h0;
      else if (zero_run_reg != BREAK_ZEROS)
         zero_run_reg <= zero_run_reg + 4'h1;
   end
   // Command decode
   logic is_data_byte;
   logic is_action;
   logic op_reset;
   logic op_begin;
   logic op_capture;
   logic op_dump;
   logic op_cancel;
   logic op_store;
   logic op_fetch;
   logic tracker_init;
   assign is_data_byte = byte_done && expect_data_reg;
   assign is_action = byte_done && !expect_data_reg;
   assign op_reset = is_action && rx_word == OP_RESET;
   assign op_begin = is_action && (rx_word == OP_INT_BEGIN || rx_word == OP_CAPTURE_DUMP_RESTART);
   assign op_capture = is_action && (rx_word == OP_CAPTURE || rx_word == OP_CAPTURE_DUMP
      || rx_word == OP_CAPTURE_DUMP_RESTART);
   assign op_dump = is_action && (rx_word == OP_DUMP || rx_word == OP_CAPTURE_DUMP
      || rx_word == OP_CAPTURE_DUMP_RESTART);
   assign op_cancel = is_action && rx_word == OP_DUMP_CANCEL;
   assign op_store = is_action && rx_word[7:5] == OP_STORE_TOP;
   assign op_fetch = is_action && rx_word[7:5] == OP_FETCH_TOP;
   assign tracker_init = line_break || (op_reset && reset_run_reg == RESET_RUN_COUNT - 2'h1);
   always_ff @(posedge mclk)
   begin
      if (!nrst || tracker_init)
      begin
         expect_data_reg <= 1'b0;
         reset_run_reg <= 2'h0;
         store_addr_reg <= 5'h00;
      end
      else if (byte_done)
      begin
         expect_data_reg <= op_store;
         store_addr_reg <= rx_word[4:0];
         reset_run_reg <= op_reset ? reset_run_reg + 2'h1 : 2'h0;
      end
   end
   // Register bank; gain and offset values are left untouched by reset
   logic [7:0] offset_reg [3];
   logic [4:0] gain_reg [3];
   logic [7:0] mode_reg;
   genvar z;
   generate
      for (z = 0; z < 3; z++)
      begin : g_zone
         always_ff @(posedge mclk)
         begin
            if (is_data_byte && store_addr_reg == 5'(2 * z))
               offset_reg[z] <= rx_word;
            if (is_data_byte && store_addr_reg == 5'(2 * z + 1))
               gain_reg[z] <= rx_word[4:0];
         end
      end
   endgenerate
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         mode_reg <= 8'h00;
      else if (is_data_byte && store_addr_reg == ADDR_MODE)
         mode_reg <= rx_word;
   end
   assign analog_sleep = mode_reg[MODE_SLEEP_BIT];
   logic [7:0] fetch_value;
   assign fetch_value = (rx_word[4:0] == ADDR_LEFT_OFFSET) ? offset_reg[0] :
      (rx_word[4:0] == ADDR_LEFT_GAIN) ? {3'h0, gain_reg[0]} :
      (rx_word[4:0] == ADDR_CENTER_OFFSET) ? offset_reg[1] :
      (rx_word[4:0] == ADDR_CENTER_GAIN) ? {3'h0, gain_reg[1]} :
      (rx_word[4:0] == ADDR_RIGHT_OFFSET) ? offset_reg[2] :
      (rx_word[4:0] == ADDR_RIGHT_GAIN) ? {3'h0, gain_reg[2]} :
      (rx_word[4:0] == ADDR_MODE) ? mode_reg : 8'h00;
   // Integrator control
   pix_state_t pix_state_reg;
   logic [4:0] pix_count_reg;
   logic pix_clear;
   assign pix_clear = op_reset || op_cancel || tracker_init;
   always_ff @(posedge mclk)
   begin
      if (!nrst || pix_clear)
      begin
         pix_state_reg <= PIX_RESET;
         pix_count_reg <= 5'h00;
      end
      else if (op_begin)
      begin
         pix_state_reg <= PIX_RESET_CYCLE;
         pix_count_reg <= 5'h00;
      end
      else if (op_capture)
         pix_state_reg <= PIX_RESET;
      else
      begin
         case (pix_state_reg)
            PIX_RESET_CYCLE:
            begin
               pix_count_reg <= pix_count_reg + 5'h01;
               if (pix_count_reg == PIXEL_RESET_CLOCKS - 5'h01)
                  pix_state_reg <= PIX_INTEGRATE;
            end
            PIX_INTEGRATE:
               pix_state_reg <= PIX_INTEGRATE;
            default:
               pix_state_reg <= PIX_RESET;
         endcase
      end
   end
   assign integrators_reset = pix_state_reg != PIX_INTEGRATE;
   assign integrating = pix_state_reg == PIX_INTEGRATE;
   // Offset then gain per zone, done digitally on the front-end level
   logic [7:0] corrected [PIXEL_COUNT];
   genvar p;
   generate
      for (p = 0; p < PIXEL_COUNT; p++)
      begin : g_pix
         localparam int ZN = (p < 34) ? 0 : (p < 68) ? 1 : 2;
         logic [9:0] shifted;
         logic [15:0] scaled;
         logic [7:0] mag;
         assign mag = {1'b0, offset_reg[ZN][6:0]} >> 2;
         assign shifted = offset_reg[ZN][7]
            ? ({2'b00, pixel_level[p]} - {2'b00, mag})
            : ({2'b00, pixel_level[p]} + {2'b00, mag});
         // Gain approx 1 + code/16, monotonic, 2.94 at top code
         assign scaled = (shifted[9] ? 16'h0000 : {6'h00, shifted}) * {11'h000, gain_reg[ZN]}
            / 16'h0010 + (shifted[9] ? 16'h0000 : {6'h00, shifted});
         assign corrected[p] = (scaled > 16'h00FF) ? 8'hFF : scaled[7:0];
      end
   endgenerate
   // Transmitter, independent of the receiver
   tx_state_t tx_state_reg;
   logic [5:0] tx_wait_reg;
   logic [3:0] tx_bit_reg;
   logic [7:0] tx_shift_reg;
   logic tx_pixels_reg;
   logic [6:0] tx_pixel_reg;
   logic [7:0] hold_word;
   logic tx_kill;
   assign tx_kill = op_reset || op_cancel || tracker_init;
   pixel_hold_mem u_hold
   (
      .mclk(mclk),
      .nrst(nrst),
      .capture(op_capture),
      .clear(op_cancel),
      .level_in(corrected),
      .rd_index(tx_pixel_reg),
      .rd_data(hold_word)
   );
   always_ff @(posedge mclk)
   begin
      if (!nrst || tx_kill)
      begin
         tx_state_reg <= TX_IDLE;
         tx_wait_reg <= 6'h00;
         tx_bit_reg <= 4'h0;
         tx_shift_reg <= 8'h00;
         tx_pixels_reg <= 1'b0;
         tx_pixel_reg <= 7'h00;
      end
      else if (op_dump)
      begin
         tx_state_reg <= TX_WAIT;
         tx_wait_reg <= DUMP_DELAY - 6'h01;
         tx_pixels_reg <= 1'b1;
         tx_pixel_reg <= 7'h00;
      end
      else if (op_fetch)
      begin
         tx_state_reg <= TX_WAIT;
         tx_wait_reg <= FETCH_DELAY - 6'h01;
         tx_pixels_reg <= 1'b0;
         tx_shift_reg <= fetch_value;
      end
      else
      begin
         case (tx_state_reg)
            TX_WAIT:
            begin
               tx_wait_reg <= tx_wait_reg - 6'h01;
               if (tx_wait_reg == 6'h00)
               begin
                  tx_state_reg <= TX_START;
                  if (tx_pixels_reg)
                     tx_shift_reg <= hold_word;
               end
            end
            TX_START:
            begin
               tx_state_reg <= TX_DATA;
               tx_bit_reg <= 4'h0;
               // Address a word ahead, so the registered store read is ready at the stop bit
               tx_pixel_reg <= tx_pixel_reg + 7'h01;
            end
            TX_DATA:
            begin
               tx_bit_reg <= tx_bit_reg + 4'h1;
               if (tx_bit_reg == WORD_BITS - 4'h1)
                  tx_state_reg <= TX_STOP;
               else
                  tx_shift_reg <= {1'b0, tx_shift_reg[7:1]};
            end
            TX_STOP:
            begin
               if (tx_pixels_reg && tx_pixel_reg <= PIXEL_LAST)
               begin
                  tx_state_reg <= TX_START;
                  tx_shift_reg <= hold_word;
               end
               else
                  tx_state_reg <= TX_IDLE;
            end
            default:
               tx_state_reg <= TX_IDLE;
         endcase
      end
   end

   // Line level chosen at rising edge, launched on the falling edge
   logic line_level;
   assign line_level = (tx_state_reg == TX_START) ? 1'b0 :
      (tx_state_reg == TX_DATA) ? tx_shift_reg[0] : 1'b1;
   always_ff @(negedge mclk)
   begin
      if (!nrst)
         data_serial_out <= 1'b1;
      else
         data_serial_out <= line_level;
   end

   property p_fetch_delay;
      @(posedge mclk) disable iff (!nrst)
      (op_fetch && !tx_kill && !op_dump) |-> ##5 (tx_state_reg == TX_START);
   endproperty
   a_fetch_delay: assert property (p_fetch_delay) else $error("fetch delay not four");
   property p_dump_delay;
      @(posedge mclk) disable iff (!nrst)
      (op_dump && !tx_kill) ##1 (!tx_kill && !op_dump && !op_fetch) [*8]
      |-> ##37 (tx_state_reg == TX_START || tx_kill);
   endproperty
   a_dump_delay: assert property (p_dump_delay) else $error("dump delay not 44");
   property p_one_stop;
      @(posedge mclk) disable iff (!nrst)
      (tx_state_reg == TX_STOP && tx_pixels_reg && tx_pixel_reg <= PIXEL_LAST
         && !tx_kill && !op_dump && !op_fetch) |=> (tx_state_reg == TX_START);
   endproperty
   a_one_stop: assert property (p_one_stop) else $error("extra stop bits");
   property p_reset_cycle;
      @(posedge mclk) disable iff (!nrst)
      $rose(pix_state_reg == PIX_RESET_CYCLE) |-> !integrating [*8];
   endproperty
   a_reset_cycle: assert property (p_reset_cycle) else $error("integration too early");
   property p_back_to_back;
      @(posedge mclk) disable iff (!nrst)
      byte_done ##1 (!command_serial_in && !line_break) |=> (rx_state_reg == RX_DATA);
   endproperty
   a_back_to_back: assert property (p_back_to_back) else $error("start bit lost");
   property p_break;
      @(posedge mclk) disable iff (!nrst)
      line_break |=> (!expect_data_reg && rx_state_reg == RX_IDLE);
   endproperty
   a_break: assert property (p_break) else $error("break did not reinit");
   property p_cancel;
      @(posedge mclk) disable iff (!nrst)
      op_cancel |=> (tx_state_reg == TX_IDLE && integrators_reset);
   endproperty
   a_cancel: assert property (p_cancel) else $error("cancel did not stop");
   property p_start_level;
      @(posedge mclk) disable iff (!nrst)
      (tx_state_reg == TX_START) |-> !data_serial_out;
   endproperty
   a_start_level: assert property (p_start_level) else $error("start bit not low");
endmodule // linear_sensor_serial_control
`default_nettype wire

// ---- core/lsc_pkg.sv ----
// Constants, encodings and states for the linear sensor serial control block
package lsc_pkg;
   localparam logic [7:0] OP_RESET = 8'h1B;
   localparam logic [7:0] OP_INT_BEGIN = 8'h08;
   localparam logic [7:0] OP_CAPTURE = 8'h10;
   localparam logic [7:0] OP_DUMP = 8'h02;
   localparam logic [7:0] OP_DUMP_CANCEL = 8'h19;
   localparam logic [7:0] OP_CAPTURE_DUMP = 8'h12;
   localparam logic [7:0] OP_CAPTURE_DUMP_RESTART = 8'h16;
   localparam logic [2:0] OP_STORE_TOP = 3'h2;
   localparam logic [2:0] OP_FETCH_TOP = 3'h3;
   localparam logic [4:0] ADDR_LEFT_OFFSET = 5'h00;
   localparam logic [4:0] ADDR_LEFT_GAIN = 5'h01;
   localparam logic [4:0] ADDR_CENTER_OFFSET = 5'h02;
   localparam logic [4:0] ADDR_CENTER_GAIN = 5'h03;
   localparam logic [4:0] ADDR_RIGHT_OFFSET = 5'h04;
   localparam logic [4:0] ADDR_RIGHT_GAIN = 5'h05;
   localparam logic [4:0] ADDR_MODE = 5'h1F;
   localparam int MODE_SLEEP_BIT = 4;
   localparam int PIXEL_COUNT = 102;
   localparam logic [6:0] PIXEL_LAST = 7'h65;
   localparam logic [6:0] ZONE_CENTER_FIRST = 7'h22;
   localparam logic [6:0] ZONE_RIGHT_FIRST = 7'h44;
   localparam logic [3:0] BREAK_ZEROS = 4'hA;
   localparam logic [1:0] RESET_RUN_COUNT = 2'h3;
   localparam logic [5:0] FETCH_DELAY = 6'h04;
   localparam logic [5:0] DUMP_DELAY = 6'h2C;
   localparam logic [4:0] PIXEL_RESET_CLOCKS = 5'h16;
   localparam logic [3:0] WORD_BITS = 4'h8;
   typedef enum logic [1:0]
   {
      RX_IDLE = 2'b00,
      RX_DATA = 2'b01
   } rx_state_t;
   typedef enum logic [2:0]
   {
      TX_IDLE = 3'b000,
      TX_WAIT = 3'b001,
      TX_START = 3'b010,
      TX_DATA = 3'b011,
      TX_STOP = 3'b100
   } tx_state_t;
   typedef enum logic [1:0]
   {
      PIX_RESET = 2'b00,
      PIX_RESET_CYCLE = 2'b01,
      PIX_INTEGRATE = 2'b10
   } pix_state_t;
endpackage

// ---- core/pixel_hold_mem.sv ----
// Held pixel value store: 102 words, captured at once, read from a register
`timescale 1ns/1ps
`default_nettype none
module pixel_hold_mem
   import lsc_pkg::*;
(
   // Clock and reset
   input wire logic mclk,
   input wire logic nrst,
   // Capture side
   input wire logic capture,
   input wire logic clear,
   input wire logic [7:0] level_in [PIXEL_COUNT],
   // Read side
   input wire logic [6:0] rd_index,
   output logic [7:0] rd_data
);
   logic [7:0] hold_reg [PIXEL_COUNT];
   genvar g;
   generate
      for (g = 0; g < PIXEL_COUNT; g++)
      begin : g_cell
         always_ff @(posedge mclk)
         begin
            if (!nrst || clear)
               hold_reg[g] <= 8'h00;
            else if (capture)
               hold_reg[g] <= level_in[g];
         end
      end
   endgenerate
   always_ff @(posedge mclk)
   begin
      if (!nrst)
         rd_data <= 8'h00;
      else if (rd_index <= PIXEL_LAST)
         rd_data <= hold_reg[rd_index];
      else
         rd_data <= 8'h00;
   end
endmodule // pixel_hold_mem
`default_nettype wire

// ---- dv/linear_sensor_serial_control_tb.sv ----
// Self-checking testbench of the linear sensor serial control block
`timescale 1ns/1ps
`default_nettype none
module linear_sensor_serial_control_tb
   import lsc_pkg::*;
;
   logic mclk = 1'b0;
   logic nrst = 1'b0;
   logic command_serial_in;
   logic data_serial_out;
   logic integrators_reset;
   logic integrating;
   logic analog_sleep;
   logic [7:0] lvl [PIXEL_COUNT];
   int mismatches = 0;
   int compares = 0;
   logic [4:0] reg_addr [6] = '{ADDR_LEFT_OFFSET, ADDR_LEFT_GAIN, ADDR_CENTER_OFFSET,
      ADDR_CENTER_GAIN, ADDR_RIGHT_OFFSET, ADDR_RIGHT_GAIN};
   // Second pass leaves the settings that the pixel checks rely on
   logic [7:0] reg_val [2][6] = '{'{8'hFF, 8'h1F, 8'h80, 8'h00, 8'h7F, 8'h11},
      '{8'h00, 8'h00, 8'h08, 8'h10, 8'h84, 8'h00}};

   always #2 mclk = ~mclk;

   linear_sensor_serial_control u_dut
   (
      .mclk(mclk),
      .nrst(nrst),
      .command_serial_in(command_serial_in),
      .data_serial_out(data_serial_out),
      .pixel_level(lvl),
      .integrators_reset(integrators_reset),
      .integrating(integrating),
      .analog_sleep(analog_sleep)
   );

   scan_controller_model u_ctl
   (
      .mclk(mclk),
      .command_serial_in(command_serial_in),
      .data_serial_out(data_serial_out)
   );

   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      compares++;
      if (seen !== exp)
      begin
         mismatches++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic complete_run;
      if (mismatches == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic get_word(output logic [7:0] w, output int waited);
      logic stop_bit;
      u_ctl.recv_word(2000, w, waited, stop_bit);
      if (waited < 0)
      begin
         check(8'h00, 8'h01);
         complete_run();
      end
      else
         check(8'(stop_bit), 8'h01);
   endtask

   task automatic reg_write(input logic [4:0] a, input logic [7:0] d);
      u_ctl.send_byte({OP_STORE_TOP, a}, 1'b0);
      u_ctl.send_byte(d, 1'b1);
      repeat (5) @(posedge mclk);
   endtask

   task automatic reg_read(input logic [4:0] a, input logic [7:0] exp);
      logic [7:0] w;
      int waited;
      u_ctl.send_byte({OP_FETCH_TOP, a}, 1'b1);
      get_word(w, waited);
      check(8'(waited), 8'h04);
      check(w, exp);
      repeat (5) @(posedge mclk);
   endtask

   task automatic action(input logic [7:0] op);
      u_ctl.send_byte(op, 1'b1);
      repeat (5) @(posedge mclk);
   endtask

   task automatic quiet(input int n);
      repeat (n)
      begin
         @(posedge mclk);
         check(8'(data_serial_out), 8'h01);
      end
   endtask

   // Expected code for the second-pass zone settings
   function automatic logic [7:0] exp_pix(input int i, input logic [7:0] l);
      if (i < 34)
         return l;
      if (i < 68)
         return (l + 8'h02) << 1;
      return l - 8'h01;
   endfunction

   // Output edges must fall on the falling clock
   always @(data_serial_out)
      if (nrst === 1'b1)
         check(8'(mclk), 8'h00);

   initial
   begin
      logic [7:0] w;
      int waited;
      for (int i = 0; i < PIXEL_COUNT; i++)
         lvl[i] = 8'(i + 10);
      repeat (5) @(posedge mclk);
      check(8'(data_serial_out), 8'h01);
      check(8'(integrators_reset), 8'h01);
      nrst <= 1'b1;
      repeat (10) @(posedge mclk);
      u_ctl.send_break(12);
      for (int p = 0; p < 2; p++)
      begin
         for (int r = 0; r < 6; r++)
            reg_write(reg_addr[r], reg_val[p][r]);
         for (int r = 0; r < 6; r++)
            reg_read(reg_addr[r], reg_val[p][r]);
      end
      reg_write(ADDR_MODE, 8'h10);
      check(8'(analog_sleep), 8'h01);
      reg_read(ADDR_MODE, 8'h10);
      reg_write(ADDR_MODE, 8'h00);
      check(8'(analog_sleep), 8'h00);
      reg_read(5'h07, 8'h00);
      repeat (3) action(OP_RESET);
      check(8'(integrators_reset), 8'h01);
      u_ctl.send_byte(OP_INT_BEGIN, 1'b1);
      repeat (18) @(posedge mclk);
      check(8'(integrating), 8'h00);
      repeat (6) @(posedge mclk);
      check(8'(integrating), 8'h01);
      check(8'(integrators_reset), 8'h00);
      repeat (20) @(posedge mclk);
      action(OP_CAPTURE);
      check(8'(integrating), 8'h00);
      // New levels after capture must not reach the dump
      for (int i = 0; i < PIXEL_COUNT; i++)
         lvl[i] <= 8'(i + 40);
      u_ctl.send_byte(OP_DUMP, 1'b1);
      fork
         for (int k = 0; k < PIXEL_COUNT; k++)
         begin
            get_word(w, waited);
            check(8'(waited), (k == 0) ? 8'h2C : 8'h01);
            check(w, exp_pix(k, 8'(k + 10)));
         end
         begin
            // Only a command without output while the dump runs
            repeat (300) @(posedge mclk);
            u_ctl.send_byte(OP_INT_BEGIN, 1'b1);
         end
      join
      // No word may follow the last pixel
      quiet(20);
      check(8'(integrating), 8'h01);
      u_ctl.send_byte(OP_CAPTURE_DUMP, 1'b1);
      get_word(w, waited);
      check(8'(waited), 8'h2C);
      check(w, exp_pix(0, 8'h28));
      action(OP_DUMP_CANCEL);
      quiet(40);
      check(8'(integrators_reset), 8'h01);
      u_ctl.send_byte(OP_CAPTURE_DUMP_RESTART, 1'b1);
      get_word(w, waited);
      check(8'(waited), 8'h2C);
      check(w, exp_pix(0, 8'h28));
      check(8'(integrating), 8'h01);
      action(OP_RESET);
      quiet(40);
      check(8'(integrators_reset), 8'h01);
      check(8'(integrating), 8'h00);
      complete_run();
   end
endmodule // linear_sensor_serial_control_tb
`default_nettype wire

// ---- dv/scan_controller_model.sv ----
// Scanner controller model: sends command frames and collects output words
`timescale 1ns/1ps
`default_nettype none
module scan_controller_model
(
   // Serial clock
   input wire logic mclk,
   // Serial link
   output var logic command_serial_in,
   input wire logic data_serial_out
);
   // Idle high so the receiver never sees a false start
   initial command_serial_in = 1'b1;

   // Entered just after a rising edge; stop=0 lets the next start follow at once
   task automatic send_byte(input logic [7:0] b, input bit stop);
      command_serial_in <= 1'b0;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         command_serial_in <= b[i];
      end
      @(posedge mclk);
      if (stop)
      begin
         command_serial_in <= 1'b1;
         @(posedge mclk);
      end
   endtask

   task automatic send_break(input int n);
      command_serial_in <= 1'b0;
      repeat (n) @(posedge mclk);
      command_serial_in <= 1'b1;
      repeat (n) @(posedge mclk);
   endtask

   // Output moves on the falling edge, so the rising edge sees a settled bit
   task automatic recv_word(input int bound, output logic [7:0] w, output int waited,
      output logic stop_bit);
      waited = 0;
      do
      begin
         @(posedge mclk);
         waited++;
      end
      while (data_serial_out !== 1'b0 && waited < bound);
      if (data_serial_out !== 1'b0)
         waited = -1;
      for (int i = 0; i < 8; i++)
      begin
         @(posedge mclk);
         w[i] = data_serial_out;
      end
      @(posedge mclk);
      stop_bit = data_serial_out;
   endtask
endmodule // scan_controller_model
`default_nettype wire
